// file: design/dsi_consts.svh
// Constants of the drive status and event indicator.
`ifndef DSI_CONSTS_SVH
`define DSI_CONSTS_SVH
`define DSI_CLK_PERIOD_NS 10
`define DSI_SLOW_PERIOD_MS 500
`define DSI_SLOW_CYCLES ((`DSI_SLOW_PERIOD_MS * 1000000) / `DSI_CLK_PERIOD_NS)
`define DSI_LIFE_THRESH_PCT 90
`define DSI_SECOND_MS 1000
`define DSI_SECOND_CYCLES ((`DSI_SECOND_MS * 1000000) / `DSI_CLK_PERIOD_NS)
`define DSI_STATE_READY 3'h2
`define DSI_STATE_ENABLED 3'h4
`define DSI_CNT_RESET 16'h0000
`define DSI_PRIMARY_EXT 8'h00
`define DSI_BACKUP_EXT 8'h01
`endif

// file: design/dsi_pkg.sv
// Types of the drive status and event indicator.
package dsi_pkg;
    typedef enum logic [1:0] {
        DSI_LVL_MESSAGE = 2'b00,
        DSI_LVL_WARNING = 2'b01,
        DSI_LVL_FAULT = 2'b10,
        DSI_LVL_OFF = 2'b11
    } dsi_level_e;
    typedef enum logic [1:0] {
        DSI_REM_OFF = 2'b00,
        DSI_REM_LINK = 2'b01,
        DSI_REM_WAIT = 2'b10,
        DSI_REM_ACTIVE = 2'b11
    } dsi_remote_e;
    typedef enum logic [1:0] {
        DSI_PH_LOAD = 2'b00,
        DSI_PH_START = 2'b01,
        DSI_PH_RUN = 2'b10,
        DSI_PH_FAILED = 2'b11
    } dsi_phase_e;
    typedef struct packed {
        logic remote;
        logic run;
        logic error;
    } dsi_lamps_s;
    typedef struct packed {
        logic have_serial;
        logic [31:0] serial;
        logic [31:0] motor_crc;
    } dsi_motor_s;
    typedef struct packed {
        logic [31:0] name;
        logic [7:0] ext;
        logic valid;
    } dsi_record_s;
endpackage

// file: design/dsi_blink_base.sv
// Common time base producing single-blink, flashing and rapid patterns.
`timescale 1ns/100ps
`include "dsi_consts.svh"
module dsi_blink_base #(
    parameter int unsigned SLOW_CYCLES = `DSI_SLOW_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Patterns
    output logic single_blink,
    output logic flashing,
    output logic rapid
);
    initial begin
        if (SLOW_CYCLES < 8) begin
            $error("SLOW_CYCLES too small");
        end
    end
    logic [31:0] div_reg;
    logic [31:0] div_next;
    logic [2:0] phase_reg;
    logic [2:0] phase_next;
    always_comb begin
        div_next = div_reg + 32'h0000_0001;
        phase_next = phase_reg;
        if (div_reg >= SLOW_CYCLES - 1) begin
            div_next = 32'h0000_0000;
            phase_next = phase_reg + 3'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            div_reg <= 32'h0000_0000;
            phase_reg <= 3'h0;
        end else begin
            div_reg <= div_next;
            phase_reg <= phase_next;
        end
    end
    // One lit slot in eight, half duty, and eight toggles per slot when SLOW_CYCLES is a power of two.
    assign single_blink = (phase_reg == 3'h0);
    assign flashing = phase_reg[0];
    assign rapid = div_reg[$clog2(SLOW_CYCLES) - 3];
endmodule

// file: design/dsi_indicator.sv
// Drive status lamps, event classification and maintenance records.
`timescale 1ns/100ps
`include "dsi_consts.svh"
module dsi_indicator
    import dsi_pkg::*;
#(
    parameter int unsigned NUM_EVENTS = 4,
    parameter int unsigned SLOW_CYCLES = `DSI_SLOW_CYCLES,
    parameter int unsigned SECOND_CYCLES = `DSI_SECOND_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Drive state
    input wire logic [2:0] device_state,
    input wire logic safe_torque_off,
    input wire logic mem_writing,
    input wire dsi_pkg::dsi_remote_e remote_mode,
    // Start-up
    input wire logic load_done,
    input wire logic load_error,
    input wire logic start_done,
    input wire logic start_error,
    // Events
    input wire logic [NUM_EVENTS-1:0] event_cause,
    input wire dsi_pkg::dsi_level_e [NUM_EVENTS-1:0] event_level,
    input wire logic [NUM_EVENTS-1:0] event_ackable,
    input wire logic [15:0] warn_time_s,
    input wire logic ack_panel,
    input wire logic ack_input,
    // Maintenance
    input wire logic maint_enable,
    input wire logic [7:0] life_indicator_value,
    input wire dsi_pkg::dsi_motor_s motor_data_param,
    input wire logic record_store,
    // Outputs
    output dsi_pkg::dsi_lamps_s lamps,
    output logic [NUM_EVENTS-1:0] message_shown,
    output logic [NUM_EVENTS-1:0] warning_pending,
    output logic [NUM_EVENTS-1:0] fault_pending,
    output logic [15:0] warn_remaining_s,
    output logic fault_reaction,
    output logic startup_error,
    output logic startup_error_phase,
    output logic config_active,
    output logic replace_recommendation_msg,
    output logic [NUM_EVENTS*16-1:0] event_counts,
    output dsi_pkg::dsi_record_s record_out
);
    import dsi_pkg::*;

    initial begin
        if (NUM_EVENTS < 1 || NUM_EVENTS > 16) begin
            $error("NUM_EVENTS out of range");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic pat_single;
    logic pat_flash;
    logic pat_rapid;
    dsi_blink_base #(.SLOW_CYCLES(SLOW_CYCLES)) u_base (
        .clk(clk),
        .rst_b(rst_b),
        .single_blink(pat_single),
        .flashing(pat_flash),
        .rapid(pat_rapid)
    );

    ////////////////////////////////////////////////////////////////////////
    // Start-up sequence: loading precedes starting.
    dsi_phase_e phase_reg;
    dsi_phase_e phase_next;
    logic serr_reg;
    logic serr_next;
    logic sphase_reg;
    logic sphase_next;
    logic cfg_reg;
    logic cfg_next;
    always_comb begin
        phase_next = phase_reg;
        serr_next = serr_reg;
        sphase_next = sphase_reg;
        case (phase_reg)
            DSI_PH_LOAD: begin
                if (load_error) begin
                    phase_next = DSI_PH_FAILED;
                    serr_next = 1'b1;
                    sphase_next = 1'b0;
                end else if (load_done) begin
                    phase_next = DSI_PH_START;
                end
            end
            DSI_PH_START: begin
                if (start_error) begin
                    phase_next = DSI_PH_FAILED;
                    serr_next = 1'b1;
                    sphase_next = 1'b1;
                end else if (start_done) begin
                    phase_next = DSI_PH_RUN;
                end
            end
            DSI_PH_RUN: phase_next = DSI_PH_RUN;
            DSI_PH_FAILED: phase_next = DSI_PH_FAILED;
            default: phase_next = DSI_PH_LOAD;
        endcase
        cfg_next = (phase_next == DSI_PH_RUN);
    end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            phase_reg <= DSI_PH_LOAD;
            serr_reg <= 1'b0;
            sphase_reg <= 1'b0;
            cfg_reg <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            serr_reg <= serr_next;
            sphase_reg <= sphase_next;
            cfg_reg <= cfg_next;
        end
    end
    wire cfg_on = cfg_reg;

    ////////////////////////////////////////////////////////////////////////
    // Per-event handling; warning time counts in whole seconds.
    logic [31:0] sec_reg;
    logic [31:0] sec_next;
    wire sec_tick = (sec_reg >= SECOND_CYCLES - 1);
    wire ack_any = cfg_on && (ack_panel || ack_input);
    logic [NUM_EVENTS-1:0] warn_reg, warn_next;
    logic [NUM_EVENTS-1:0] fault_reg, fault_next;
    logic [NUM_EVENTS-1:0] msg_reg, msg_next;
    logic [NUM_EVENTS-1:0] prev_reg, prev_next;
    logic [15:0] remain_reg [NUM_EVENTS];
    logic [15:0] remain_next [NUM_EVENTS];
    logic [15:0] cnt_reg [NUM_EVENTS];
    logic [15:0] cnt_next [NUM_EVENTS];
    genvar gi;
    generate
        for (gi = 0; gi < NUM_EVENTS; gi++) begin : g_ev
            wire rise = event_cause[gi] && !prev_reg[gi];
            always_comb begin
                prev_next[gi] = event_cause[gi];
                cnt_next[gi] = cnt_reg[gi];
                if (rise && cnt_reg[gi] != 16'hFFFF) begin
                    cnt_next[gi] = cnt_reg[gi] + 16'h0001;
                end
                msg_next[gi] = event_cause[gi]
                    && event_level[gi] == DSI_LVL_MESSAGE;
                warn_next[gi] = warn_reg[gi];
                remain_next[gi] = remain_reg[gi];
                fault_next[gi] = fault_reg[gi];
                if (fault_reg[gi] && ack_any && event_ackable[gi]
                        && !event_cause[gi]) begin
                    fault_next[gi] = 1'b0;
                end
                if (event_level[gi] == DSI_LVL_WARNING) begin
                    if (!event_cause[gi]) begin
                        warn_next[gi] = 1'b0;
                    end else if (!warn_reg[gi] && !fault_reg[gi]) begin
                        warn_next[gi] = 1'b1;
                        remain_next[gi] = warn_time_s;
                    end else if (warn_reg[gi] && sec_tick) begin
                        if (remain_reg[gi] <= 16'h0001) begin
                            warn_next[gi] = 1'b0;
                            remain_next[gi] = 16'h0000;
                            fault_next[gi] = 1'b1;
                        end else begin
                            remain_next[gi] = remain_reg[gi] - 16'h0001;
                        end
                    end
                end else begin
                    warn_next[gi] = 1'b0;
                end
                if (event_level[gi] == DSI_LVL_FAULT && event_cause[gi]) begin
                    fault_next[gi] = 1'b1;
                end
            end
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    cnt_reg[gi] <= `DSI_CNT_RESET;
                    remain_reg[gi] <= 16'h0000;
                end else begin
                    cnt_reg[gi] <= cnt_next[gi];
                    remain_reg[gi] <= remain_next[gi];
                end
            end
            assign event_counts[gi*16 +: 16] = cnt_reg[gi];
            a_fault_entry: assert property (
                @(posedge clk) disable iff (!rst_b)
                (event_cause[gi] && event_level[gi] == DSI_LVL_FAULT)
                |=> fault_pending[gi])
                else $error("fault not entered");
            a_warn_clear: assert property (
                @(posedge clk) disable iff (!rst_b)
                (event_level[gi] == DSI_LVL_WARNING && !event_cause[gi])
                |=> !warning_pending[gi])
                else $error("warning kept");
        end
    endgenerate
    logic [15:0] shown_next;
    logic react_next;
    logic react_reg;
    always_comb begin
        sec_next = sec_tick ? 32'h0000_0000 : sec_reg + 32'h0000_0001;
        react_next = |fault_next;
        shown_next = 16'h0000;
        for (int i = NUM_EVENTS - 1; i >= 0; i--) begin
            if (warn_next[i]) begin
                shown_next = remain_next[i];
            end
        end
    end
    logic [15:0] shown_reg;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sec_reg <= 32'h0000_0000;
            warn_reg <= '0;
            fault_reg <= '0;
            msg_reg <= '0;
            prev_reg <= '0;
            shown_reg <= 16'h0000;
            react_reg <= 1'b0;
        end else begin
            sec_reg <= sec_next;
            warn_reg <= warn_next;
            fault_reg <= fault_next;
            msg_reg <= msg_next;
            prev_reg <= prev_next;
            shown_reg <= shown_next;
            react_reg <= react_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lamps, recommendation and maintenance record.
    dsi_lamps_s lamps_reg, lamps_next;
    logic rec_reg, rec_next;
    dsi_record_s record_reg, record_next;
    logic [NUM_EVENTS-1:0] msg_show;
    always_comb begin
        msg_show = msg_reg & {NUM_EVENTS{pat_flash}};
        rec_next = maint_enable
            && life_indicator_value >= 8'(`DSI_LIFE_THRESH_PCT);
        case (remote_mode)
            DSI_REM_OFF: lamps_next.remote = 1'b0;
            DSI_REM_LINK: lamps_next.remote = pat_single;
            DSI_REM_WAIT: lamps_next.remote = pat_flash;
            DSI_REM_ACTIVE: lamps_next.remote = 1'b1;
            default: lamps_next.remote = 1'b0;
        endcase
        lamps_next.error = 1'b0;
        lamps_next.run = 1'b0;
        if (!cfg_on) begin
            lamps_next.error = pat_rapid;
        end else if (|fault_reg) begin
            lamps_next.error = 1'b1;
        end else if (|warn_reg) begin
            lamps_next.error = pat_flash;
            if (device_state == `DSI_STATE_ENABLED) begin
                lamps_next.run = 1'b1;
            end else if (device_state == `DSI_STATE_READY) begin
                lamps_next.run = pat_flash;
            end
        end else if (mem_writing) begin
            lamps_next.run = pat_rapid;
        end else if (safe_torque_off) begin
            lamps_next.run = pat_single;
        end else if (device_state == `DSI_STATE_ENABLED) begin
            lamps_next.run = 1'b1;
        end else if (device_state == `DSI_STATE_READY) begin
            lamps_next.run = pat_flash;
        end
        record_next = record_reg;
        if (record_store) begin
            record_next.name = motor_data_param.have_serial
                ? motor_data_param.serial
                : motor_data_param.motor_crc;
            record_next.ext = `DSI_PRIMARY_EXT;
            record_next.valid = 1'b1;
        end else if (record_reg.valid
                && record_reg.ext == `DSI_PRIMARY_EXT) begin
            record_next.ext = `DSI_BACKUP_EXT;
        end else begin
            record_next.valid = 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            lamps_reg <= '0;
            rec_reg <= 1'b0;
            record_reg <= '0;
        end else begin
            lamps_reg <= lamps_next;
            rec_reg <= rec_next;
            record_reg <= record_next;
        end
    end
    logic [NUM_EVENTS-1:0] msgo_reg;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            msgo_reg <= '0;
        end else begin
            msgo_reg <= msg_show;
        end
    end

    assign lamps = lamps_reg;
    assign message_shown = msgo_reg;
    assign warning_pending = warn_reg;
    assign fault_pending = fault_reg;
    assign warn_remaining_s = shown_reg;
    assign fault_reaction = react_reg;
    assign startup_error = serr_reg;
    assign startup_error_phase = sphase_reg;
    assign config_active = cfg_reg;
    assign replace_recommendation_msg = rec_reg;
    assign record_out = record_reg;

    a_recommend_flag: assert property (
        @(posedge clk) disable iff (!rst_b)
        (maint_enable
            && life_indicator_value >= 8'(`DSI_LIFE_THRESH_PCT))
        |=> replace_recommendation_msg)
        else $error("recommendation missing");
    a_fault_red_on: assert property (
        @(posedge clk) disable iff (!rst_b)
        (cfg_on && |fault_reg) |=> lamps.error && !lamps.run)
        else $error("fault lamp wrong");
    a_remote_on: assert property (
        @(posedge clk) disable iff (!rst_b)
        remote_mode == DSI_REM_ACTIVE |=> lamps.remote)
        else $error("remote lamp off");
    a_count_step: assert property (
        @(posedge clk) disable iff (!rst_b)
        (event_cause[0] && !prev_reg[0] && cnt_reg[0] != 16'hFFFF)
        |=> cnt_reg[0] == $past(cnt_reg[0]) + 16'h0001)
        else $error("counter not stepped");
    a_start_order: assert property (
        @(posedge clk) disable iff (!rst_b)
        (phase_reg == DSI_PH_LOAD && !load_error && !load_done)
        |=> phase_reg == DSI_PH_LOAD)
        else $error("start before load");
    // A store held high restarts the primary copy, so the backup waits.
    a_backup_copy: assert property (
        @(posedge clk) disable iff (!rst_b)
        record_store |=> record_out.ext == `DSI_PRIMARY_EXT
        ##1 ($past(record_store) || record_out.ext == `DSI_BACKUP_EXT))
        else $error("backup missing");
endmodule

// file: bench/dsi_panel_model.sv
// Operator panel and programmable acknowledge input model.
`timescale 1ns/100ps
module dsi_panel_model (
    // Clock
    input wire logic clk,
    // Commands from the bench
    input wire logic press_panel,
    input wire logic press_input,
    input wire logic [3:0] hold_cycles,
    // Acknowledge lines
    output logic ack_panel,
    output logic ack_input
);
    logic [3:0] left_panel = 4'h0;
    logic [3:0] left_input = 4'h0;
    // A press is held for hold_cycles edges, so both a quick tap and a slow
    // operator can be played; an idle switch drives its line low.
    // Counters move by non-blocking assignment on the edge, so the design
    // sees a press from the following edge on and no race with the bench.
    always @(posedge clk) begin
        if (press_panel) left_panel <= hold_cycles;
        else if (left_panel != 4'h0) left_panel <= left_panel - 4'h1;
        if (press_input) left_input <= hold_cycles;
        else if (left_input != 4'h0) left_input <= left_input - 4'h1;
    end
    assign ack_panel = (left_panel != 4'h0);
    assign ack_input = (left_input != 4'h0);
endmodule

// file: bench/dsi_indicator_tb.sv
// Self-checking testbench of the drive status and event indicator.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
    miscompares++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module dsi_indicator_tb;
    import dsi_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [2:0] device_state;
    logic safe_torque_off, mem_writing, load_done, load_error;
    logic start_done, start_error, maint_enable, record_store;
    logic press_panel, press_input, ack_panel, ack_input;
    dsi_remote_e remote_mode;
    logic [3:0] event_cause, event_ackable;
    dsi_level_e [3:0] event_level;
    logic [15:0] warn_time_s, warn_remaining_s;
    logic [7:0] life_indicator_value;
    dsi_motor_s motor_data_param;
    dsi_lamps_s lamps;
    logic [3:0] message_shown, warning_pending, fault_pending;
    logic fault_reaction, startup_error, startup_error_phase;
    logic config_active, replace_recommendation_msg;
    logic [63:0] event_counts;
    dsi_record_s record_out;
    int miscompares = 0;
    int checks_done = 0;
    always #5 clk = ~clk;
    dsi_indicator #(.NUM_EVENTS(4), .SLOW_CYCLES(64), .SECOND_CYCLES(16)) dut (
        .clk(clk), .rst_b(rst_b), .device_state(device_state),
        .safe_torque_off(safe_torque_off), .mem_writing(mem_writing),
        .remote_mode(remote_mode), .load_done(load_done),
        .load_error(load_error), .start_done(start_done),
        .start_error(start_error), .event_cause(event_cause),
        .event_level(event_level), .event_ackable(event_ackable),
        .warn_time_s(warn_time_s), .ack_panel(ack_panel),
        .ack_input(ack_input), .maint_enable(maint_enable),
        .life_indicator_value(life_indicator_value),
        .motor_data_param(motor_data_param), .record_store(record_store),
        .lamps(lamps), .message_shown(message_shown),
        .warning_pending(warning_pending), .fault_pending(fault_pending),
        .warn_remaining_s(warn_remaining_s), .fault_reaction(fault_reaction),
        .startup_error(startup_error),
        .startup_error_phase(startup_error_phase),
        .config_active(config_active),
        .replace_recommendation_msg(replace_recommendation_msg),
        .event_counts(event_counts), .record_out(record_out));
    dsi_panel_model panel (.clk(clk), .press_panel(press_panel),
        .press_input(press_input), .hold_cycles(4'h2),
        .ack_panel(ack_panel), .ack_input(ack_input));
    ////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask
    // Lamp codes: 0 off, 1 on, 2 single blink, 3 flashing, 4 rapid.
    function automatic int cls(input int on, input int tg);
        if (on == 0) return 0;
        if (on == 512) return 1;
        if (tg <= 3) return 2;
        if (tg <= 20) return 3;
        return 4;
    endfunction
    // One window of 512 cycles spans eight slots of the shortened time base.
    task automatic lamp_chk(input string nm, input int r, g, e);
        int on[3] = '{0, 0, 0};
        int tg[3] = '{0, 0, 0};
        int unk = 0;
        dsi_lamps_s p;
        tick(4);
        p = lamps;
        repeat (512) begin
            tick(1);
            for (int i = 0; i < 3; i++) begin
                on[i] += int'(lamps[i]);
                tg[i] += int'(lamps[i] != p[i]);
            end
            unk += int'($isunknown(lamps));
            p = lamps;
        end
        if (r >= 0) `CHK({nm, "_remote"}, r, cls(on[2], tg[2]))
        if (g >= 0) `CHK({nm, "_run"}, g, cls(on[1], tg[1]))
        if (e >= 0) `CHK({nm, "_error"}, e, cls(on[0], tg[0]))
        `CHK({nm, "_known"}, 0, unk)
    endtask
    task automatic do_reset();
        rst_b = 1'b0;
        {device_state, safe_torque_off, mem_writing, load_done} = '0;
        {load_error, start_done, start_error, maint_enable} = '0;
        {record_store, press_panel, press_input} = '0;
        remote_mode = DSI_REM_OFF;
        event_cause = 4'h0;
        event_ackable = 4'h0;
        event_level = '{default: DSI_LVL_OFF};
        warn_time_s = 16'h0003;
        life_indicator_value = 8'h00;
        motor_data_param = '0;
        tick(5);
        rst_b = 1'b1;
        `CHK("rst_counts", 64'h0000_0000_0000_0000, event_counts)
        `CHK("rst_config", 1'b0, config_active)
    endtask
    task automatic ack(input logic from_panel);
        press_panel = from_panel;
        press_input = !from_panel;
        tick(1);
        {press_panel, press_input} = 2'b00;
        tick(5);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_startup();
        load_error = 1'b1;
        tick(3);
        `CHK("load_err", 2'b10, {startup_error, startup_error_phase})
        do_reset();
        load_done = 1'b1;
        tick(2);
        start_error = 1'b1;
        tick(3);
        `CHK("start_err", 2'b11, {startup_error, startup_error_phase})
        do_reset();
        lamp_chk("no_cfg", -1, 0, 4);
        load_done = 1'b1;
        tick(3);
        `CHK("cfg_early", 1'b0, config_active)
        start_done = 1'b1;
        tick(3);
        `CHK("cfg_on", 1'b1, config_active)
    endtask
    task automatic t_lamps();
        int exp_r[4] = '{0, 2, 3, 1};
        for (int i = 0; i < 4; i++) begin
            remote_mode = dsi_remote_e'(i);
            lamp_chk("remote", exp_r[i], -1, -1);
        end
        safe_torque_off = 1'b1;
        lamp_chk("sto", -1, 2, 0);
        safe_torque_off = 1'b0;
        device_state = 3'h2;
        lamp_chk("ready", -1, 3, 0);
        device_state = 3'h4;
        lamp_chk("enabled", -1, 1, 0);
        mem_writing = 1'b1;
        lamp_chk("writing", -1, 4, 0);
        mem_writing = 1'b0;
        warn_time_s = 16'h0064;
        event_level[1] = DSI_LVL_WARNING;
        event_cause[1] = 1'b1;
        lamp_chk("warn4", -1, 1, 3);
        device_state = 3'h2;
        lamp_chk("warn2", -1, 3, 3);
        event_cause[1] = 1'b0;
        tick(4);
    endtask
    // A shown message flashes: half of any two-slot window is lit.
    task automatic t_message();
        int on;
        event_level[0] = DSI_LVL_MESSAGE;
        for (int k = 1; k <= 2; k++) begin
            event_cause[0] = 1'b1;
            tick(3);
            on = 0;
            repeat (128) begin
                tick(1);
                on += int'(message_shown[0] === 1'b1);
            end
            `CHK("msg_flash", 64, on)
            `CHK("msg_no_react", 1'b0, fault_reaction)
            event_cause[0] = 1'b0;
            tick(3);
            on = 0;
            repeat (128) begin
                tick(1);
                on += int'(message_shown[0] !== 1'b0);
            end
            `CHK("msg_off", 0, on)
            `CHK("msg_count", 16'(k), event_counts[15:0])
        end
    endtask
    task automatic t_warning();
        int n = 0;
        warn_time_s = 16'h0003;
        event_cause[1] = 1'b1;
        tick(1);
        `CHK("warn_pend", 1'b1, warning_pending[1])
        `CHK("warn_rem", 16'h0003, warn_remaining_s)
        `CHK("warn_no_react", 1'b0, fault_reaction)
        event_cause[1] = 1'b0;
        tick(3);
        `CHK("warn_gone", 2'b00, {warning_pending[1], fault_pending[1]})
        event_cause[1] = 1'b1;
        while (fault_pending[1] !== 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        `CHK("warn_expiry", 1'b1, n >= 32 && n <= 56)
        event_cause[1] = 1'b0;
        event_ackable[1] = 1'b1;
        ack(1'b0);
        `CHK("warn_fault_ack", 1'b0, fault_pending[1])
    endtask
    task automatic t_fault();
        event_level[2] = DSI_LVL_FAULT;
        event_cause[2] = 1'b1;
        tick(3);
        `CHK("flt_react", 2'b11, {fault_reaction, fault_pending[2]})
        lamp_chk("fault", -1, 0, 1);
        ack(1'b1);
        `CHK("flt_cause_held", 1'b1, fault_pending[2])
        event_cause[2] = 1'b0;
        ack(1'b0);
        `CHK("flt_not_ackable", 1'b1, fault_pending[2])
        event_ackable[2] = 1'b1;
        ack(1'b1);
        `CHK("flt_acked", 2'b00, {fault_reaction, fault_pending[2]})
        `CHK("ev_counts", 48'h0000_0001_0003, event_counts[63:16])
    endtask
    task automatic t_maint();
        logic [8:0] tab[4] = '{9'h1_59, 9'h1_5A, 9'h1_FF, 9'h0_5A};
        logic exp_m[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
        for (int i = 0; i < 4; i++) begin
            {maint_enable, life_indicator_value} = tab[i];
            tick(3);
            `CHK("replace", exp_m[i], replace_recommendation_msg)
        end
    endtask
    task automatic rec_chk(input logic [31:0] nm);
        int n = 0;
        record_store = 1'b1;
        tick(1);
        record_store = 1'b0;
        while (!(record_out.valid === 1'b1 && record_out.ext === 8'h00)
               && n < 4) begin
            tick(1);
            n++;
        end
        `CHK("rec_primary", {nm, 8'h00, 1'b1}, record_out)
        tick(1);
        `CHK("rec_backup", {nm, 8'h01, 1'b1}, record_out)
        tick(3);
    endtask
    task automatic t_record();
        motor_data_param = '{1'b1, 32'h0377_4434, 32'h0BB5_A846};
        rec_chk(32'h0377_4434);
        motor_data_param.have_serial = 1'b0;
        rec_chk(32'h0BB5_A846);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset();
        t_startup();
        t_lamps();
        t_message();
        t_warning();
        t_fault();
        t_maint();
        t_record();
        final_report();
    end
    // The run needs about 7k cycles; the watchdog allows ample headroom.
    initial begin
        #300000;
        miscompares++;
        final_report();
    end
endmodule
